// ### verilog/dsp_cfg.svh
// Constants for the drive serial protocol slave: framing codes, limits and error encodings.
// Assumes a byte-level receiver and transmitter on the same clock mark frame ends and take bytes.
//
// Functional notes
// R1: ASCII failure reply: NAK, station, 'Y', code, sum, EOT. The code sends the request's command character where 'Y' stands.
// R2: Unknown function or command gives illegal-function code.
// R3: Missing parameter address gives illegal-address code.
// R4: Unacceptable write data gives illegal-value code.
// R5: Read-only or run-locked write gives write-mode code.
// R6: Wrong frame length gives frame-length error code. The code answers binary frames of wrong length with the illegal-value code.
// R7: Binary station must equal configured station number.
// R8: Binary start address is parameter communication address.
// R9: Function 03 reads points, replies byte count, data.
// R10: Function 04 uses same layouts as 03.
// R11: Function 06 writes one register, echoes address, data.
// R12: Function 10h writes words, replies address and count.
// R13: ASCII checksum is low byte of character sum.
// R14: ASCII 16-bit values are four hex digits, MSD first.
// R15: Station 255 commands execute without any reply. The code does this for ASCII frames only.
// R16: Binary exception: station, function with top bit, code.
// R17: Binary frames end with Modbus CRC, low first.
// R18: Binary frames failing CRC are dropped silently.
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH
`define DSP_RX_MAX 44
`define DSP_WORDS 8
`define DSP_ENQ 8'h05
`define DSP_ACK 8'h06
`define DSP_NAK 8'h15
`define DSP_EOT 8'h04
`define DSP_CMD_READ 8'h52
`define DSP_CMD_WRITE 8'h57
`define DSP_CMD_MON_REG 8'h58
`define DSP_CMD_MON_RUN 8'h59
`define DSP_BCAST 8'hFF
`define DSP_CH_FUNC 16'h4946
`define DSP_CH_ADDR 16'h4941
`define DSP_CH_VALUE 16'h4944
`define DSP_CH_WMODE 16'h574D
`define DSP_CH_FRAME 16'h4645
`define DSP_FC_RD_HOLD 8'h03
`define DSP_FC_RD_INPUT 8'h04
`define DSP_FC_WR_ONE 8'h06
`define DSP_FC_WR_MANY 8'h10
`define DSP_FC_EXC_BIT 8'h80
`define DSP_EXC_FUNC 8'h01
`define DSP_EXC_ADDR 8'h02
`define DSP_EXC_VALUE 8'h03
`define DSP_CRC_INIT 16'hFFFF
`define DSP_CRC_POLY 16'hA001
`endif

// ### verilog/dsp_pkg.sv
// Types and shared helpers of the drive serial protocol slave.
// Assumes dsp_cfg.svh is on the include path.
package dsp_pkg;
`include "dsp_cfg.svh"
	typedef logic [`DSP_RX_MAX-1:0][7:0] dsp_buf_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic eof;
	} dsp_rx_t;
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} dsp_tx_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dsp_par_req_t;
	typedef enum logic [1:0] {PAR_OK, PAR_NO_ADDR, PAR_BAD_VALUE, PAR_WRITE_MODE} dsp_par_status_t;
	typedef struct packed {
		logic ack;
		dsp_par_status_t status;
		logic [15:0] rdata;
	} dsp_par_rsp_t;
	typedef enum logic [2:0] {ERR_NONE, ERR_FUNC, ERR_ADDR, ERR_VALUE, ERR_WMODE, ERR_FRAME} dsp_err_t;
	typedef enum logic [2:0] {S_IDLE, S_PARSE, S_ACCESS, S_WAIT, S_RESP, S_SEND} dsp_state_t;

	// Non-hex characters decode as zero; the checksum catches corrupted digits.
	function automatic logic [3:0] hex2nib(input logic [7:0] c);
		logic [7:0] v;
		v = 8'h00;
		if (c >= 8'h30 && c <= 8'h39) begin
			v = c - 8'h30;
		end else if (c >= 8'h41 && c <= 8'h46) begin
			v = c - 8'h37;
		end
		return v[3:0];
	endfunction

	function automatic logic [7:0] nib2hex(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction

	function automatic logic [15:0] hex4(input dsp_buf_t b, input logic [5:0] p);
		return {hex2nib(b[p]), hex2nib(b[p + 6'd1]), hex2nib(b[p + 6'd2]), hex2nib(b[p + 6'd3])};
	endfunction
endpackage

// ### verilog/dsp_crc16.sv
// Byte-serial Modbus CRC-16 accumulator.
// Assumes the caller clears it before each frame and feeds one byte per enable.
`timescale 1ns/1ps
module dsp_crc16 (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic clr,
	input wire logic en,
	input wire logic [7:0] data,
	output logic [15:0] crc
);
	import dsp_pkg::*;
	typedef struct packed {
		logic [15:0] crc;
	} dsp_crc_st_t;
	dsp_crc_st_t q, d;

	always_comb begin
		d = q;
		if (clr) begin
			d.crc = `DSP_CRC_INIT;
		end else if (en) begin
			d.crc = q.crc ^ {8'h00, data};
			for (int b = 0; b < 8; b++) begin
				d.crc = d.crc[0] ? ((d.crc >> 1) ^ `DSP_CRC_POLY) : (d.crc >> 1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{crc: `DSP_CRC_INIT};
		end else if (ce) begin
			q <= d;
		end
	end

	assign crc = q.crc;
endmodule

// ### verilog/dsp_slave.sv
// Serial protocol slave: decodes ASCII and binary request frames and builds replies.
// Assumes rx bytes and frame-end pulses, tx acceptance and parameter answers come
// from logic on the same clock.
`timescale 1ns/1ps
module dsp_slave (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic proto_ascii,
	input wire logic [7:0] station_number_setting,
	input dsp_pkg::dsp_rx_t rx,
	input wire logic tx_ready,
	output dsp_pkg::dsp_tx_t tx,
	output dsp_pkg::dsp_par_req_t par,
	input dsp_pkg::dsp_par_rsp_t par_rsp,
	output logic busy
);
	import dsp_pkg::*;
	typedef struct packed {
		dsp_state_t st;
		dsp_buf_t rbuf;
		logic [5:0] len;
		logic ovf;
		logic [7:0] sum;
		logic ascii;
		logic bcast;
		logic [7:0] cmd;
		logic [15:0] base;
		logic [3:0] n;
		logic [3:0] i;
		dsp_err_t err;
		logic [`DSP_WORDS-1:0][15:0] word;
		logic [`DSP_WORDS-1:0][15:0] mon;
		logic [3:0] mon_n;
		logic [5:0] k;
		logic [5:0] body;
		logic [5:0] total;
		logic [7:0] tsum;
		dsp_tx_t tx;
		dsp_par_req_t par;
		logic busy;
	} dsp_st_t;
	dsp_st_t q, d;
	logic [15:0] rx_crc;
	logic [15:0] tx_crc;
	logic rx_take;
	logic tx_feed;
	logic [7:0] tx_byte;
	logic [5:0] j;
	logic [15:0] echar;
	logic [7:0] exc;
	logic [15:0] cnt;
	logic [7:0] body_sum;

	assign rx_take = rx.valid && q.st == S_IDLE;
	assign tx_feed = q.st == S_SEND && (!q.tx.valid || tx_ready) && q.k < q.body;

	dsp_crc16 u_rx_crc (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.clr(q.st == S_PARSE),
		.en(rx_take && !rx.eof),
		.data(rx.data),
		.crc(rx_crc)
	);

	dsp_crc16 u_tx_crc (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.clr(q.st == S_RESP),
		.en(tx_feed),
		.data(tx_byte),
		.crc(tx_crc)
	);

	// Error kind to ASCII code characters and binary exception codes.
	always_comb begin
		echar = `DSP_CH_FRAME;
		exc = `DSP_EXC_VALUE;
		unique case (q.err)
			ERR_FUNC: begin
				echar = `DSP_CH_FUNC; // R2
				exc = `DSP_EXC_FUNC;
			end
			ERR_ADDR: begin
				echar = `DSP_CH_ADDR; // R3
				exc = `DSP_EXC_ADDR;
			end
			ERR_VALUE: echar = `DSP_CH_VALUE; // R4
			ERR_WMODE: begin
				echar = `DSP_CH_WMODE; // R5
				exc = `DSP_EXC_FUNC;
			end
			ERR_FRAME: echar = `DSP_CH_FRAME; // R6
			ERR_NONE: echar = `DSP_CH_FRAME;
		endcase
	end

	// Byte k of the reply; body bytes first, then checksum and terminator (ASCII) or CRC (binary).
	always_comb begin
		j = q.k - 6'd4;
		tx_byte = `DSP_EOT;
		if (q.ascii) begin
			if (q.k < q.body) begin
				unique case (q.k)
					6'd0: tx_byte = (q.err != ERR_NONE) ? `DSP_NAK : `DSP_ACK; // R1
					6'd1: tx_byte = q.rbuf[1];
					6'd2: tx_byte = q.rbuf[2];
					6'd3: tx_byte = q.cmd;
					default: begin
						if (q.err != ERR_NONE) begin
							tx_byte = j[0] ? echar[7:0] : echar[15:8]; // R1
						end else begin
							tx_byte = nib2hex(4'(q.word[j[4:2]] >> (6'd12 - {j[1:0], 2'b00}))); // R14
						end
					end
				endcase
			end else if (q.k == q.body) begin
				tx_byte = nib2hex(q.tsum[7:4]); // R13
			end else if (q.k == q.body + 6'd1) begin
				tx_byte = nib2hex(q.tsum[3:0]); // R13
			end
		end else begin
			if (q.k < q.body) begin
				if (q.err != ERR_NONE) begin
					tx_byte = (q.k == 6'd0) ? q.rbuf[0] :
						(q.k == 6'd1) ? (q.cmd | `DSP_FC_EXC_BIT) : exc; // R16
				end else if (q.cmd == `DSP_FC_RD_HOLD || q.cmd == `DSP_FC_RD_INPUT) begin
					if (q.k < 6'd2) begin
						tx_byte = q.rbuf[q.k];
					end else if (q.k == 6'd2) begin
						tx_byte = {3'b000, q.n, 1'b0}; // R9 R10
					end else begin
						j = q.k - 6'd3;
						tx_byte = j[0] ? q.word[j[4:1]][7:0] : q.word[j[4:1]][15:8]; // R9
					end
				end else begin
					tx_byte = q.rbuf[q.k]; // R11 R12
				end
			end else begin
				tx_byte = (q.k == q.body) ? tx_crc[7:0] : tx_crc[15:8]; // R17
			end
		end
	end

	always_comb begin
		d = q;
		d.par.req = 1'b0;
		cnt = {q.rbuf[4], q.rbuf[5]};
		body_sum = q.sum - q.rbuf[q.len - 6'd1] - q.rbuf[q.len - 6'd2] - q.rbuf[q.len - 6'd3];
		unique case (q.st)
			S_IDLE: begin
				if (rx_take && rx.eof) begin
					d.st = S_PARSE;
					d.ascii = proto_ascii;
				end else if (rx_take) begin
					if (q.len == 6'(`DSP_RX_MAX)) begin
						d.ovf = 1'b1;
					end else begin
						d.rbuf[q.len] = rx.data;
						d.len = q.len + 6'd1;
						if (q.len != 6'd0) begin
							d.sum = q.sum + rx.data;
						end
					end
				end
			end
			S_PARSE: begin
				d.st = S_ACCESS;
				d.err = ERR_NONE;
				d.i = 4'd0;
				d.bcast = 1'b0;
				d.par.we = 1'b0;
				if (q.ascii) begin
					d.cmd = q.rbuf[3];
					d.base = hex4(q.rbuf, 6'd4);
					d.n = hex2nib(q.rbuf[8]);
					d.bcast = {hex2nib(q.rbuf[1]), hex2nib(q.rbuf[2])} == `DSP_BCAST; // R15
					if (q.ovf || q.len < 6'd7 || q.rbuf[0] != `DSP_ENQ
						|| q.rbuf[q.len - 6'd1] != `DSP_EOT) begin
						d.st = S_IDLE;
					end else if (body_sum != {hex2nib(q.rbuf[q.len - 6'd3]),
						hex2nib(q.rbuf[q.len - 6'd2])}) begin
						d.st = S_IDLE; // R13
					end else if (!d.bcast && {hex2nib(q.rbuf[1]), hex2nib(q.rbuf[2])}
						!= station_number_setting) begin
						d.st = S_IDLE;
					end else begin
						unique case (q.rbuf[3])
							`DSP_CMD_READ, `DSP_CMD_WRITE: begin
								d.par.we = q.rbuf[3] == `DSP_CMD_WRITE;
								if (q.len != (d.par.we ? 6'd12 + {d.n, 2'b00} : 6'd12)) begin
									d.err = ERR_FRAME; // R6
								end else if (d.n == 4'd0 || d.n > 4'(`DSP_WORDS)) begin
									d.err = ERR_VALUE; // R4
								end
							end
							`DSP_CMD_MON_REG: begin
								d.n = hex2nib(q.rbuf[4]);
								if (q.len != 6'd8 + {d.n, 2'b00}) begin
									d.err = ERR_FRAME; // R6
								end else if (d.n == 4'd0 || d.n > 4'(`DSP_WORDS)) begin
									d.err = ERR_VALUE; // R4
								end
							end
							`DSP_CMD_MON_RUN: begin
								d.n = q.mon_n;
								if (q.len != 6'd7) begin
									d.err = ERR_FRAME; // R1 R6
								end
							end
							default: d.err = ERR_FUNC; // R2
						endcase
					end
				end else begin
					d.cmd = q.rbuf[1];
					d.base = {q.rbuf[2], q.rbuf[3]}; // R8
					d.n = cnt[3:0];
					if (q.ovf || q.len < 6'd4 || rx_crc != 16'h0000) begin
						d.st = S_IDLE; // R18
					end else if (q.rbuf[0] != station_number_setting) begin
						d.st = S_IDLE; // R7
					end else begin
						unique case (q.rbuf[1])
							`DSP_FC_RD_HOLD, `DSP_FC_RD_INPUT: begin
								if (q.len != 6'd8 || cnt == 16'h0000 || cnt > 16'(`DSP_WORDS)) begin
									d.err = ERR_VALUE; // R9 R10
								end
							end
							`DSP_FC_WR_ONE: begin
								d.n = 4'd1;
								d.par.we = 1'b1;
								if (q.len != 6'd8) begin
									d.err = ERR_VALUE; // R11
								end
							end
							`DSP_FC_WR_MANY: begin
								d.par.we = 1'b1;
								if (cnt == 16'h0000 || cnt > 16'(`DSP_WORDS) || q.rbuf[6] != {cnt[6:0], 1'b0}
									|| q.len != 6'd9 + {1'b0, cnt[3:0], 1'b0}) begin
									d.err = ERR_VALUE; // R12
								end
							end
							default: d.err = ERR_FUNC; // R2 R16
						endcase
					end
				end
				if (d.err != ERR_NONE || d.n == 4'd0) begin
					d.st = (d.st == S_IDLE) ? S_IDLE : S_RESP;
				end
			end
			S_ACCESS: begin
				if (q.ascii && q.cmd == `DSP_CMD_MON_REG) begin
					// Registration only latches the list; addresses are checked when it runs.
					d.mon[q.i[2:0]] = hex4(q.rbuf, 6'(5 + 4 * q.i));
					d.i = q.i + 4'd1;
					if (d.i == q.n) begin
						d.mon_n = q.n;
						d.st = S_RESP;
					end
				end else begin
					d.par.req = 1'b1;
					d.par.addr = (q.ascii && q.cmd == `DSP_CMD_MON_RUN) ? q.mon[q.i[2:0]] :
						q.base + 16'(q.i); // R8
					if (q.ascii) begin
						d.par.wdata = hex4(q.rbuf, 6'(9 + 4 * q.i)); // R14
					end else if (q.cmd == `DSP_FC_WR_ONE) begin
						d.par.wdata = {q.rbuf[4], q.rbuf[5]}; // R11
					end else begin
						d.par.wdata = {q.rbuf[6'(7 + 2 * q.i)], q.rbuf[6'(8 + 2 * q.i)]}; // R12
					end
					d.st = S_WAIT;
				end
			end
			S_WAIT: begin
				if (par_rsp.ack) begin
					unique case (par_rsp.status)
						PAR_NO_ADDR: d.err = ERR_ADDR; // R3
						PAR_BAD_VALUE: d.err = ERR_VALUE; // R4
						PAR_WRITE_MODE: d.err = ERR_WMODE; // R5
						PAR_OK: d.err = ERR_NONE;
					endcase
					d.word[q.i[2:0]] = q.par.we ? q.par.wdata : par_rsp.rdata;
					d.i = q.i + 4'd1;
					d.st = (d.err != ERR_NONE || d.i == q.n) ? S_RESP : S_ACCESS;
				end
			end
			S_RESP: begin
				d.k = 6'd0;
				d.tsum = 8'h00;
				if (q.ascii) begin
					if (q.err != ERR_NONE) begin
						d.body = 6'd6; // R1
					end else if (q.cmd == `DSP_CMD_MON_REG) begin
						d.body = 6'd4;
					end else begin
						d.body = 6'd4 + {q.n, 2'b00};
					end
					d.total = d.body + 6'd3;
				end else begin
					if (q.err != ERR_NONE) begin
						d.body = 6'd3; // R16
					end else if (q.cmd == `DSP_FC_RD_HOLD || q.cmd == `DSP_FC_RD_INPUT) begin
						d.body = 6'd3 + {1'b0, q.n, 1'b0};
					end else begin
						d.body = 6'd6;
					end
					d.total = d.body + 6'd2; // R17
				end
				d.st = q.bcast ? S_IDLE : S_SEND; // R15
			end
			S_SEND: begin
				if (!q.tx.valid || tx_ready) begin
					if (q.k == q.total) begin
						d.tx.valid = 1'b0;
						d.st = S_IDLE;
					end else begin
						d.tx.valid = 1'b1;
						d.tx.data = tx_byte;
						d.tx.last = q.k == q.total - 6'd1;
						d.k = q.k + 6'd1;
						if (q.k != 6'd0 && q.k < q.body) begin
							d.tsum = q.tsum + tx_byte; // R13
						end
					end
				end
			end
		endcase
		if (d.st == S_IDLE && q.st != S_IDLE) begin
			d.len = 6'd0;
			d.ovf = 1'b0;
			d.sum = 8'h00;
		end
		d.busy = d.st != S_IDLE;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign tx = q.tx;
	assign par = q.par;
	assign busy = q.busy;
endmodule

// ### tb/dsp_par_model.sv
// Parameter map model answering the slave's parameter requests.
// Assumes one-cycle requests on the slave's clock; slow adds wait states.
`timescale 1ns/1ps
module dsp_par_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input dsp_pkg::dsp_par_req_t par,
	output dsp_pkg::dsp_par_rsp_t par_rsp
);
	import dsp_pkg::*;
	logic pend_q;
	logic [2:0] wait_q;
	logic [15:0] junk_q;
	always_ff @(posedge clk) begin
		junk_q <= ~junk_q;
		if (rst) begin
			pend_q <= 1'b0;
			wait_q <= 3'd0;
			junk_q <= 16'h5A5A;
		end else if (par.req) begin
			pend_q <= 1'b1;
			wait_q <= slow ? 3'd4 : 3'd0;
		end else if (wait_q != 3'd0) begin
			wait_q <= wait_q - 3'd1;
		end else begin
			pend_q <= 1'b0;
		end
	end
	// Read data outside the answer toggles so a late sample cannot pass by luck.
	always_comb begin
		par_rsp.ack = pend_q && wait_q == 3'd0;
		par_rsp.rdata = par_rsp.ack ? ~par.addr : junk_q;
		par_rsp.status = PAR_OK;
		if (par.addr >= 16'hF000) begin
			par_rsp.status = PAR_NO_ADDR;
		end else if (par.we && par.addr < 16'h0010) begin
			par_rsp.status = PAR_WRITE_MODE;
		end else if (par.we && par.wdata == 16'hFFFF) begin
			par_rsp.status = PAR_BAD_VALUE;
		end
	end
endmodule

// ### tb/dsp_slave_monitor.sv
// Port checker for the serial protocol slave.
// Assumes it is bound to the slave and sees its ports only.
`timescale 1ns/1ps
`include "dsp_cfg.svh"
module dsp_slave_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic proto_ascii,
	input wire logic [7:0] station_number_setting,
	input dsp_pkg::dsp_rx_t rx,
	input wire logic tx_ready,
	input dsp_pkg::dsp_tx_t tx,
	input dsp_pkg::dsp_par_req_t par,
	input dsp_pkg::dsp_par_rsp_t par_rsp,
	input wire logic busy
);
	import dsp_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_tx_hold: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
		else $error("tx byte changed before acceptance");
	chk_req_pulse: assert property (par.req |=> !par.req)
		else $error("parameter request longer than one cycle");
	chk_req_hold: assert property (!par.req |-> $stable(par.addr) && $stable(par.wdata))
		else $error("parameter address moved between requests");
	chk_eof_busy: assert property (ce && rx.valid && rx.eof && !busy |=> busy)
		else $error("frame end did not start processing");
	chk_idle_quiet: assert property (!busy |-> !tx.valid && !par.req)
		else $error("activity while idle");
	chk_ascii_lead: assert property (proto_ascii && $rose(tx.valid) |->
		tx.data == `DSP_ACK || tx.data == `DSP_NAK)
		else $error("ascii reply lead byte wrong");
	chk_ascii_tail: assert property (proto_ascii && tx.valid && tx.last |->
		tx.data == `DSP_EOT)
		else $error("ascii reply not closed by end code");
	chk_busy_release: assert property (ce && tx.valid && tx.last && tx_ready |->
		##[1:2] !busy)
		else $error("busy held after last reply byte");
endmodule
bind dsp_slave dsp_slave_monitor mon_u (.clk(clk), .rst(rst), .ce(ce),
	.proto_ascii(proto_ascii), .station_number_setting(station_number_setting),
	.rx(rx), .tx_ready(tx_ready), .tx(tx), .par(par), .par_rsp(par_rsp), .busy(busy));

// ### tb/drive_serial_protocol_slave_bench.sv
// Self-checking bench for the serial protocol slave.
// Assumes the parameter map model and the bound checker are compiled with it.
`timescale 1ns/1ps
module drive_serial_protocol_slave_bench;
	import dsp_pkg::*;
	typedef logic [7:0] dsp_bq_t[$];
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic proto_ascii = 1'b0;
	logic slow = 1'b0;
	logic tx_ready = 1'b1;
	logic [7:0] station_number_setting = 8'h01;
	logic [1:0] stall_q = 2'd0;
	dsp_rx_t rx = '0;
	dsp_tx_t tx;
	dsp_par_req_t par;
	dsp_par_rsp_t par_rsp;
	logic busy;
	int errors = 0;
	int tests_run = 0;
	int lastpos;
	dsp_bq_t got;
	dsp_bq_t nil;
	always #10 clk = ~clk;
	// Every fourth cycle the line refuses a byte so held bytes get exercised.
	always @(negedge clk) begin
		stall_q <= stall_q + 2'd1;
		tx_ready <= stall_q != 2'd3;
	end
	always @(posedge clk) begin
		if (tx.valid === 1'b1 && tx_ready) begin
			got.push_back(tx.data);
			if (tx.last === 1'b1) lastpos = got.size();
		end
	end
	dsp_slave dut_u (.clk(clk), .rst(rst), .ce(ce), .proto_ascii(proto_ascii),
		.station_number_setting(station_number_setting), .rx(rx), .tx_ready(tx_ready),
		.tx(tx), .par(par), .par_rsp(par_rsp), .busy(busy));
	dsp_par_model map_u (.clk(clk), .rst(rst), .slow(slow), .par(par), .par_rsp(par_rsp));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction
	function automatic dsp_bq_t af(input logic [7:0] lead, input string s);
		dsp_bq_t q;
		logic [7:0] sum;
		q = {lead};
		sum = 8'h00;
		for (int i = 0; i < s.len(); i++) begin
			q.push_back(s[i]);
			sum = sum + s[i];
		end
		q.push_back(hx(sum[7:4]));
		q.push_back(hx(sum[3:0]));
		q.push_back(8'h04);
		return q;
	endfunction
	function automatic dsp_bq_t bf(input dsp_bq_t q);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
			end
		end
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		return q;
	endfunction
	// Sends one frame plus its end beat, then waits out processing and the reply.
	task automatic run(input logic asc, input dsp_bq_t req, input dsp_bq_t exp);
		int n;
		got = {};
		lastpos = 0;
		proto_ascii <= asc;
		foreach (req[i]) begin
			@(negedge clk);
			rx <= '{valid: 1'b1, data: req[i], eof: 1'b0};
		end
		@(negedge clk);
		rx <= '{valid: 1'b1, data: 8'h00, eof: 1'b1};
		@(negedge clk);
		rx <= '0;
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		if (n == 2000) begin
			errors++;
			report_and_stop();
		end
		@(negedge clk);
		check("reply length", got.size(), exp.size());
		foreach (exp[i]) if (i < got.size()) check("reply byte", got[i], exp[i]);
		if (exp.size() > 0) check("last flag position", lastpos, exp.size());
	endtask
	task automatic t_bin_read();
		slow <= 1'b1;
		run(0, bf({8'h01, 8'h03, 8'h00, 8'h20, 8'h00, 8'h02}),
			bf({8'h01, 8'h03, 8'h04, 8'hFF, 8'hDF, 8'hFF, 8'hDE}));
		run(0, bf({8'h01, 8'h04, 8'h00, 8'h20, 8'h00, 8'h01}),
			bf({8'h01, 8'h04, 8'h02, 8'hFF, 8'hDF}));
		slow <= 1'b0;
	endtask
	task automatic t_bin_write();
		run(0, bf({8'h01, 8'h06, 8'h00, 8'h30, 8'h12, 8'h34}),
			bf({8'h01, 8'h06, 8'h00, 8'h30, 8'h12, 8'h34}));
		run(0, bf({8'h01, 8'h10, 8'h11, 8'h02, 8'h00, 8'h02, 8'h04, 8'h00, 8'h32, 8'h00, 8'h64}),
			bf({8'h01, 8'h10, 8'h11, 8'h02, 8'h00, 8'h02}));
	endtask
	task automatic t_bin_exc();
		run(0, bf({8'h01, 8'h03, 8'hF0, 8'h00, 8'h00, 8'h01}), bf({8'h01, 8'h83, 8'h02}));
		run(0, bf({8'h01, 8'h05, 8'h00, 8'h20, 8'h00, 8'h01}), bf({8'h01, 8'h85, 8'h01}));
		run(0, bf({8'h01, 8'h06, 8'h00, 8'h05, 8'h00, 8'h01}), bf({8'h01, 8'h86, 8'h01}));
		run(0, bf({8'h01, 8'h06, 8'h00, 8'h30, 8'hFF, 8'hFF}), bf({8'h01, 8'h86, 8'h03}));
	endtask
	task automatic t_bin_drop();
		dsp_bq_t q;
		q = bf({8'h01, 8'h03, 8'h00, 8'h20, 8'h00, 8'h01});
		q[q.size() - 1] = ~q[q.size() - 1];
		run(0, q, nil);
		run(0, bf({8'h02, 8'h03, 8'h00, 8'h20, 8'h00, 8'h01}), nil);
	endtask
	task automatic t_ascii();
		run(1, af(8'h05, "01R00201"), af(8'h06, "01RFFDF"));
		run(1, af(8'h05, "01X1F000"), af(8'h06, "01X"));
		run(1, af(8'h05, "01Y"), af(8'h15, "01YIA"));
		run(1, af(8'h05, "01W000510001"), af(8'h15, "01WWM"));
		run(1, af(8'h05, "01W00301FFFF"), af(8'h15, "01WID"));
		run(1, af(8'h05, "01R002010"), af(8'h15, "01RFE"));
		run(1, af(8'h05, "01r00201"), af(8'h15, "01rIF"));
		run(1, af(8'h05, "FFW003011234"), nil);
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_bin_read();
		t_bin_write();
		t_bin_exc();
		t_bin_drop();
		t_ascii();
		report_and_stop();
	end
endmodule
